// file: dv/ecs_link_properties.sv
// Purpose: Link checks between the two channel ends
// Assumes: Both ends on pclk; status follows control by one edge
// Notes:   Sees only the shared process image
`timescale 1ns/100ps
module ecs_link_properties
  import ecs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] channel_control_byte,
  input wire logic [7:0] second_control_byte,
  input wire logic [ECS_DW-1:0] out_data0,
  input wire logic [7:0] channel_status_byte,
  input wire logic [7:0] second_status_byte,
  input wire logic [ECS_DW-1:0] in_data0
);
  // ----------------------------------------
  // Aliases and assertions
  // ----------------------------------------
  wire [7:0] cb = channel_control_byte;
  wire [7:0] sb = channel_status_byte;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Mode and reserved bit low one edge after process mode
  AST_PD_MODE: assert property (!cb[7] |=> sb[7:6] == 2'b00) else $error("process mode status");
  // Echo must be the whole control byte, not only the index
  AST_REG_ECHO: assert property (cb[7] |=> sb == $past(cb)) else $error("register echo");
  AST_SB2: assert property (second_status_byte == 8'h00) else $error("second status");
  // Ack trails the strobe by two edges: into the ack flop, then into status
  AST_PRESET_ACK: assert property (!cb[7] && !$past(cb[7]) |=> sb[2] == $past(cb[2], 2))
    else $error("preset ack");
  AST_DISARM: assert property (!cb[7] && !cb[0] |=> !sb[0]) else $error("disarm ack");
  AST_REG_HI: assert property (cb[7] |=> in_data0[31:16] == 16'h0000) else $error("reg data");
  // Valid may only appear while armed in process mode
  AST_VALID_RISE: assert property ($rose(sb[0]) && !sb[7] && !$past(sb[7])
    |-> $past(cb[0]) && !$past(cb[7])) else $error("valid rise");
  // Arm may only rise after a process-mode status with valid low
  AST_REARM_ORDER: assert property ($rose(cb[0]) && !cb[7] && !$past(cb[7])
    |-> !$past(sb[0]) && !$past(sb[7])) else $error("rearm order");
  AST_VALID_HOLD: assert property (sb[0] && !sb[7] && cb[0] && !cb[7] |=> sb[0]) else $error("valid hold");
endmodule

// file: dv/encoder_channel_ctrl_status_bytes_tb.sv
// Purpose: Drives the controller over APB and checks the channel end
// Assumes: One APB access phase per transfer, status one edge late
// Notes:   Expected reads are queued by the driver, checked by a monitor
`timescale 1ns/100ps
module encoder_channel_ctrl_status_bytes_tb;
  import ecs_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic gate_in = 1'b0, zero_in = 1'b0, count_up = 1'b0, count_dn = 1'b0, cmp_level = 1'b0, meas_done = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v, d;
  logic pready, pslverr, output_level, ex;
  logic [ECS_DW-1:0] counter_value, latch_value;
  logic [32:0] expq[$];
  logic [5:0] idx;
  logic [4:0] b;
  int err_total = 0, n_compared = 0, seed = 80;

  always #2.5 pclk = ~pclk;
  ecs_link_if u_ecs_link_if();
  ecs_device u_ecs_device(.pclk(pclk), .presetn(presetn), .link(u_ecs_link_if), .gate_in(gate_in),
    .zero_in(zero_in), .count_up(count_up), .count_dn(count_dn), .cmp_level(cmp_level),
    .meas_done(meas_done), .output_level(output_level), .counter_value(counter_value), .latch_value(latch_value));
  ecs_controller u_ecs_controller(.pclk(pclk), .presetn(presetn), .link(u_ecs_link_if), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ecs_link_properties u_ecs_link_properties(.pclk(pclk), .presetn(presetn),
    .channel_control_byte(u_ecs_link_if.channel_control_byte),
    .second_control_byte(u_ecs_link_if.second_control_byte), .out_data0(u_ecs_link_if.out_data0),
    .channel_status_byte(u_ecs_link_if.channel_status_byte),
    .second_status_byte(u_ecs_link_if.second_status_byte), .in_data0(u_ecs_link_if.in_data0));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Two idle edges after release keep status settled for the next read
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] exp);
    expq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask
  task pulse;
    zero_in <= 1'b1;
    @(posedge pclk);
    zero_in <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // Status word: echo flag set, pslverr low
  function automatic logic [32:0] st(input logic [7:0] s);
    st = {25'h0000001, s};
  endfunction

  // Read data taken only at the completing edge
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      chk({pslverr, prdata}, expq.pop_front());
    end
  end
  // Watchdog sized well above the sequence length
  initial begin
    repeat (20000) @(posedge pclk);
    $display("ERROR %0t watchdog expired", $time);
    err_total++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ECS_A_STAT, st(8'h00));
    rd(ECS_A_IND, 33'h0);
    rd(12'h010, {1'b1, 32'h0});
    // Unarmed zero edges too: valid must stay low
    for (int i = 0; i < 32; i++) begin
      b = i[4:0];
      cmp_level <= 1'($random(seed));
      gate_in <= b[0];
      zero_in <= b[1];
      meas_done <= b[2];
      apb(1'b1, ECS_A_CTRL, {24'h0, 1'b0, b[4], b[3], 5'h00});
      ex = b[4] ? cmp_level : b[3];
      chk({32'h0, output_level}, {32'h0, ex});
      rd(ECS_A_STAT, st({2'b00, ex, b[0], b[1], 1'b0, b[2], 1'b0}));
    end
    gate_in <= 1'b0;
    zero_in <= 1'b0;
    meas_done <= 1'b0;
    v = $random(seed);
    apb(1'b1, ECS_A_OUTD, v);
    apb(1'b1, ECS_A_CTRL, 32'h04);
    chk({1'b0, counter_value}, {1'b0, v});
    rd(ECS_A_STAT, st(8'h04));
    count_up <= 1'b1;
    repeat (3) @(posedge pclk);
    count_up <= 1'b0;
    rd(ECS_A_IND, {1'b0, v + 32'd3});
    apb(1'b1, ECS_A_CTRL, 32'h01);
    pulse();
    chk({1'b0, latch_value}, {1'b0, v + 32'd3});
    rd(ECS_A_STAT, st(8'h01));
    count_up <= 1'b1;
    @(posedge pclk);
    count_up <= 1'b0;
    pulse();
    chk({1'b0, latch_value}, {1'b0, v + 32'd3});
    apb(1'b1, ECS_A_CTRL, 32'h02);
    rd(ECS_A_STAT, st(8'h00));
    apb(1'b1, ECS_A_CTRL, 32'h03);
    pulse();
    rd(ECS_A_IND, {1'b0, v + 32'd4});
    // Both count inputs high hold, then two down steps
    count_up <= 1'b1;
    count_dn <= 1'b1;
    repeat (2) @(posedge pclk);
    count_up <= 1'b0;
    repeat (2) @(posedge pclk);
    count_dn <= 1'b0;
    @(posedge pclk);
    chk({1'b0, counter_value}, {1'b0, v + 32'd2});
    for (int j = 0; j < 4; j++) begin
      idx = 6'($random(seed));
      d = $random(seed);
      apb(1'b1, ECS_A_OUTD, d);
      apb(1'b1, ECS_A_CTRL, {24'h0, 2'b11, idx});
      apb(1'b1, ECS_A_CTRL, {24'h0, 2'b10, idx});
      rd(ECS_A_STAT, st({2'b10, idx}));
      rd(ECS_A_IND, {17'h0, d[15:0]});
    end
    apb(1'b1, ECS_A_CTRL, 32'h00);
    rd(ECS_A_STAT, st(8'h00));
    // Second reset in mid-run
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({1'b0, counter_value}, 33'h0);
    rd(ECS_A_STAT, st(8'h00));
    print_verdict();
  end
endmodule

// file: verilog/ecs_controller.sv
// Purpose: Controller end: drives the output image from APB registers
// Assumes: Software sequences register accesses through the status word
// Notes:   Hardware enforces the zero-capture rearm handshake
`timescale 1ns/100ps
module ecs_controller
  import ecs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  ecs_link_if.ctl link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic acc;
  logic hit_ctrl;
  logic hit_outd;
  logic hit_stat;
  logic hit_ind;
  logic mapped;
  logic wr_ctrl;
  logic wr_outd;

  assign acc = psel && penable;
  assign hit_ctrl = paddr == ECS_A_CTRL;
  assign hit_outd = paddr == ECS_A_OUTD;
  assign hit_stat = paddr == ECS_A_STAT;
  assign hit_ind = paddr == ECS_A_IND;
  assign mapped = hit_ctrl || hit_outd || hit_stat || hit_ind;
  assign wr_ctrl = acc && pwrite && hit_ctrl;
  assign wr_outd = acc && pwrite && hit_outd;
  // Zero wait states; unmapped answers with an error
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // ----------------------------------------
  // Output image registers
  // ----------------------------------------
  logic [7:0] ctrl_r;
  logic [31:0] outd_r;
  logic arm_r;
  logic arm_nxt;
  logic sw_arm;
  logic valid_in;
  logic echo_ok;
  logic arm_wait;
  logic [7:0] sb;

  assign sb = link.channel_status_byte;
  assign sw_arm = ctrl_r[ECS_CB_ARM];
  // A register echo is no valid report, so it counts as still valid
  assign valid_in = sb[ECS_SB_VALID] || sb[ECS_SB_MODE];
  // Arm rises only once the device has shown valid low after a disarm;
  // register mode drops it, as bit 0 is then an index bit
  assign arm_nxt = (!sw_arm || ctrl_r[ECS_CB_MODE]) ? 1'b0 : (arm_r || !valid_in);
  assign arm_wait = !ctrl_r[ECS_CB_MODE] && sw_arm && !arm_r;
  // Echo of mode, direction and index tells software the access landed
  assign echo_ok = ctrl_r[ECS_CB_MODE] ? (sb == ctrl_r) : !sb[ECS_SB_MODE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ECS_BYTE_RST;
      outd_r <= ECS_WORD_RST;
      arm_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[7:0];
      end
      if (wr_outd) begin
        outd_r <= pwdata;
      end
      arm_r <= arm_nxt;
    end
  end

  // Arm bit only means arm in process mode
  assign link.channel_control_byte = ctrl_r[ECS_CB_MODE] ? ctrl_r
                                   : {ctrl_r[7:1], arm_r};
  assign link.second_control_byte = ECS_BYTE_RST;
  assign link.out_data0 = outd_r;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      prdata = {24'h000000, ctrl_r};
    end else if (hit_outd) begin
      prdata = outd_r;
    end else if (hit_stat) begin
      prdata = {22'h000000, arm_wait, echo_ok, sb};
    end else if (hit_ind) begin
      prdata = link.in_data0;
    end
  end

endmodule

// file: verilog/ecs_device.sv
// Purpose: Encoder channel end: status byte, preset, zero capture, register access
// Assumes: gate_in, zero_in and the count inputs are synchronous to pclk
// Notes:   Counter is a plain up/down counter; comparator result is an input
`timescale 1ns/100ps

// Operation
// - Process mode reports mode status bit zero
// - Status bit five shows output level
// - Status bit four mirrors gate input
// - Status bit three mirrors zero input
// - Status bit two acknowledges preset taken
// - Armed zero edge captures counter, sets valid
// - After capture, ignore zero pulses until rearm
// - Clearing arm clears valid status bit
// - Controller rearms: clear, await valid low, set
// - Controller sets control bit seven for registers
// - Bit six direction, bits five-zero register index
// - Write stores low 16 bits of output word into indexed register
// - Register mode gives no valid process data
// - Register mode sets status bit seven
// - Status echoes index and direction of access
// - Second control ignored, second status zero
// - Control bit seven low selects process mode
// - Preset rising edge loads counter from word
// - Armed capture stores at first latch pulse
// - Manual output only when compare disabled
module ecs_device
  import ecs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  ecs_link_if.dev link,
  input wire logic gate_in,
  input wire logic zero_in,
  input wire logic count_up,
  input wire logic count_dn,
  input wire logic cmp_level,
  input wire logic meas_done,
  output logic output_level,
  output logic [ECS_DW-1:0] counter_value,
  output logic [ECS_DW-1:0] latch_value
);

  // ----------------------------------------
  // Control byte decoding
  // ----------------------------------------
  logic [7:0] cb;
  logic reg_mode;
  logic rw_write;
  logic [ECS_IDX_W-1:0] idx;
  logic preset_bit;
  logic arm_bit;
  logic cmp_en;

  // Second control byte is never looked at
  assign cb = link.channel_control_byte;
  assign reg_mode = cb[ECS_CB_MODE];
  assign rw_write = cb[ECS_CB_RW];
  assign idx = cb[ECS_IDX_MSB:0];
  assign preset_bit = cb[ECS_CB_PRESET];
  assign arm_bit = cb[ECS_CB_ARM];
  assign cmp_en = cb[ECS_CB_CMPEN];

  // ----------------------------------------
  // Mode qualifiers
  // ----------------------------------------
  // In register mode the low bits carry the index, so every process
  // function is gated here; otherwise an index write would preset,
  // arm a capture or move the output pin
  logic proc_mode;
  logic proc_arm;

  assign proc_mode = !reg_mode;
  assign proc_arm = proc_mode && arm_bit;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [ECS_DW-1:0] cnt_r;
  logic [ECS_DW-1:0] cnt_nxt;
  logic [ECS_DW-1:0] latch_r;
  logic valid_r;
  logic valid_nxt;
  logic zero_d_r;
  logic preset_d_r;
  logic preset_ack_r;
  logic out_r;
  logic out_nxt;
  logic [7:0] sb_r;
  logic [7:0] sb_nxt;
  logic [ECS_DW-1:0] ind_r;
  logic [ECS_DW-1:0] ind_nxt;
  logic [ECS_RW_W-1:0] regs [ECS_NREG];

  // ----------------------------------------
  // Counter with preset
  // ----------------------------------------
  // Opposite count requests cancel, so both high holds the count
  function automatic logic [ECS_DW-1:0] step_count(
    input logic [ECS_DW-1:0] cur,
    input logic up,
    input logic dn
  );
    step_count = cur;
    if (up && !dn) begin
      step_count = cur + 32'h0000_0001;
    end else if (dn && !up) begin
      step_count = cur - 32'h0000_0001;
    end
  endfunction

  logic preset_rise;
  logic zero_rise;
  logic capture;
  logic [ECS_DW-1:0] cnt_step;

  // Preset edge only counts in process mode, so a mode switch is not a preset
  assign preset_rise = proc_mode && preset_bit && !preset_d_r;
  assign cnt_step = step_count(cnt_r, count_up, count_dn);
  assign cnt_nxt = preset_rise ? link.out_data0 : cnt_step;

  // Capture needs arm and no pending capture; later pulses do nothing
  assign zero_rise = zero_in && !zero_d_r;
  assign capture = proc_arm && !valid_r && zero_rise;
  // Disarm clears valid; capture can't coincide since it needs arm.
  // Register mode freezes valid, but the controller holds arm low there, so valid clears once process mode returns
  assign valid_nxt = !proc_mode ? valid_r :
                     (!arm_bit ? 1'b0 : (capture ? 1'b1 : valid_r));

  // Manual level only steers the pin with compare off; the pin holds
  // through register access since bits 6 and 5 then mean other things
  assign out_nxt = !proc_mode ? out_r : (cmp_en ? cmp_level : cb[ECS_CB_MANOUT]);

  // ----------------------------------------
  // Status byte and input word
  // ----------------------------------------
  // Register mode shows register data, never stale process values
  assign sb_nxt = reg_mode ? {1'b1, rw_write, idx}
                           : {1'b0, 1'b0, out_r, gate_in, zero_in,
                              preset_ack_r, meas_done, valid_nxt};
  assign ind_nxt = reg_mode ? {16'h0000, regs[idx]}
                 : (cb[ECS_CB_LATSEL] ? latch_r : cnt_r);

  // Core registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= ECS_WORD_RST;
      latch_r <= ECS_WORD_RST;
      valid_r <= 1'b0;
      zero_d_r <= 1'b0;
      preset_d_r <= 1'b0;
      preset_ack_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      if (capture) begin
        latch_r <= cnt_r;
      end
      valid_r <= valid_nxt;
      zero_d_r <= zero_in;
      preset_d_r <= preset_bit;
      // Ack follows the strobe once the value is in the counter
      preset_ack_r <= !reg_mode && preset_bit;
      out_r <= out_nxt;
    end
  end

  // Status and data flops
  // One edge of latency: status answers the control byte of the edge before
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sb_r <= ECS_BYTE_RST;
      ind_r <= ECS_WORD_RST;
    end else begin
      sb_r <= sb_nxt;
      ind_r <= ind_nxt;
    end
  end

  // ----------------------------------------
  // Internal register file
  // ----------------------------------------
  // Writes repeat while the request is held; harmless since the value is the same
  // All words reset to zero, so a read before any write returns zero
  genvar gi;
  generate
    for (gi = 0; gi < ECS_NREG; gi = gi + 1) begin : g_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs[gi] <= ECS_REG_RST;
        end else if (reg_mode && rw_write && idx == ECS_IDX_W'(gi)) begin
          regs[gi] <= link.out_data0[ECS_RW_W-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every data output except the constant second status byte comes straight from a flop
  assign link.channel_status_byte = sb_r;
  assign link.second_status_byte = ECS_BYTE_RST;
  assign link.in_data0 = ind_r;
  assign output_level = out_r;
  assign counter_value = cnt_r;
  assign latch_value = latch_r;

endmodule

// file: verilog/ecs_link_if.sv
// Purpose: Process image between controller and encoder channel
// Assumes: Both ends on pclk; the bench connects clock and reset to each end
// Notes:   Second control/status bytes are carried but have no meaning
`timescale 1ns/100ps
interface ecs_link_if;
  import ecs_pkg::*;

  // ----------------------------------------
  // Output image (controller to device), input image (device to controller)
  // ----------------------------------------
  logic [7:0] channel_control_byte;
  logic [7:0] second_control_byte;
  logic [ECS_DW-1:0] out_data0;
  logic [7:0] channel_status_byte;
  logic [7:0] second_status_byte;
  logic [ECS_DW-1:0] in_data0;

  modport dev (
    input channel_control_byte,
    input second_control_byte,
    input out_data0,
    output channel_status_byte,
    output second_status_byte,
    output in_data0
  );

  modport ctl (
    output channel_control_byte,
    output second_control_byte,
    output out_data0,
    input channel_status_byte,
    input second_status_byte,
    input in_data0
  );
endinterface

// file: verilog/ecs_pkg.sv
// Purpose: Shared constants for the encoder channel control/status byte link
// Assumes: One channel; bytes and words move in parallel each pclk cycle
// Notes:   Used by both link ends and the controller APB register map
package ecs_pkg;

  // ----------------------------------------
  // Control byte fields
  // ----------------------------------------
  localparam int ECS_CB_MODE = 7;      // register_mode_select
  localparam int ECS_CB_CMPEN = 6;     // compare_function_enable (process mode)
  localparam int ECS_CB_RW = 6;        // direction (register mode)
  localparam int ECS_CB_MANOUT = 5;    // manual_output_level
  localparam int ECS_CB_PRESET = 2;    // counter_preset_strobe
  localparam int ECS_CB_LATSEL = 1;    // input word shows latch when set
  localparam int ECS_CB_ARM = 0;       // zero_capture_arm
  localparam int ECS_IDX_MSB = 5;
  localparam int ECS_IDX_W = 6;

  // ----------------------------------------
  // Status byte fields
  // ----------------------------------------
  localparam int ECS_SB_MODE = 7;
  localparam int ECS_SB_RW = 6;
  localparam int ECS_SB_OUT = 5;
  localparam int ECS_SB_GATE = 4;
  localparam int ECS_SB_ZERO = 3;
  localparam int ECS_SB_PRESET = 2;
  localparam int ECS_SB_MEAS = 1;
  localparam int ECS_SB_VALID = 0;

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int ECS_DW = 32;          // process data word
  localparam int ECS_RW_W = 16;        // internal register width
  localparam int ECS_NREG = 64;
  localparam logic [7:0] ECS_BYTE_RST = 8'h00;
  localparam logic [31:0] ECS_WORD_RST = 32'h0000_0000;
  localparam logic [15:0] ECS_REG_RST = 16'h0000;

  // ----------------------------------------
  // Controller APB map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] ECS_A_CTRL = 12'h000;
  localparam logic [11:0] ECS_A_OUTD = 12'h004;
  localparam logic [11:0] ECS_A_STAT = 12'h008;
  localparam logic [11:0] ECS_A_IND = 12'h00c;
  localparam int ECS_ST_ECHO = 8;      // echo-matched flag in status word
  localparam int ECS_ST_ARMHOLD = 9;   // arm request waiting for valid to drop

endpackage
